// ### rtl/gpio_abc_regs.svh
// Register map, field layout, reset values and pin masks of the port A/B/C block.
// Assumes it is included by bare name from files that need the numbers.
`ifndef GPIO_ABC_REGS_SVH
`define GPIO_ABC_REGS_SVH

// ------------------------------------------------------------
// Byte offsets on the register bus
// ------------------------------------------------------------
`define OFS_PORT_A_PIN_DATA 5'h00
`define OFS_PORT_A_PIN_FUNCTION 5'h04
`define OFS_PORT_B_PIN_DATA 5'h08
`define OFS_PORT_B_PIN_FUNCTION 5'h0C
`define OFS_PORT_C_PIN_DATA 5'h10
`define OFS_PORT_C_PIN_FUNCTION 5'h14

// ------------------------------------------------------------
// Field layout and reset values
// ------------------------------------------------------------
`define PIN_COUNT 8
`define SEL_WIDTH 2
`define DATA_FIELD_MSB 7
`define FNC_FIELD_MSB 15
`define RST_PIN_DATA 8'h00
`define RST_PIN_FUNCTION 16'h0000

// ------------------------------------------------------------
// Pins that own a second alternate function
// ------------------------------------------------------------
`define ALT2_PINS_PORT_A 8'hCC
`define ALT2_PINS_PORT_B 8'h00
`define ALT2_PINS_PORT_C 8'hF8

`endif

// ### rtl/gpio_abc_pkg.sv
// Types shared by the port A/B/C block and its pin multiplexer.
// Assumes the register header supplies all numeric constants.
package gpio_abc_pkg;

    // Pin selector codes, in selector order 00, 01, 10, 11.
    typedef enum logic [1:0] {
        MODE_INPUT,
        MODE_ALT1,
        MODE_OUTPUT,
        MODE_ALT2
    } pin_mode_t;

    // Eight pin bits for each of the three ports, index 0 is port A.
    typedef logic [2:0][7:0] port_bits_t;

    // Pin selectors of one port, two bits per pin.
    typedef logic [15:0] pin_function_t;

endpackage

// ### rtl/pad_mux_if.sv
// Carrier between the register block and one port's pin multiplexer.
// Assumes one instance per port; the register side owns selectors and data.
`timescale 1ns/1ps

interface pad_mux_if;
    import gpio_abc_pkg::*;

    pin_function_t sel; // Selector word of the port.
    logic [7:0] data; // Stored output data of the port.
    logic [7:0] alt1_out; // Alternate function 1 output level.
    logic [7:0] alt1_oe; // Alternate function 1 output enable.
    logic [7:0] alt2_out; // Alternate function 2 output level.
    logic [7:0] alt2_oe; // Alternate function 2 output enable.
    logic [7:0] pad_out; // Resolved pad output level.
    logic [7:0] pad_oe; // Resolved pad output enable.
    logic [7:0] out_mode; // Pins that are general-purpose outputs.

    modport owner (
        output sel, data, alt1_out, alt1_oe, alt2_out, alt2_oe,
        input pad_out, pad_oe, out_mode
    );
    modport mux (
        input sel, data, alt1_out, alt1_oe, alt2_out, alt2_oe,
        output pad_out, pad_oe, out_mode
    );
endinterface

// ### rtl/gpio_pin_mux.sv
// Per-port pin function multiplexer, purely combinational.
// Assumes the owner registers the pad outputs it produces.
`timescale 1ns/1ps
`include "gpio_abc_regs.svh"

module gpio_pin_mux #(
    parameter logic [7:0] ALT2_PINS = 8'h00
) (
    // Connection to the register block.
    pad_mux_if.mux bus
);
    import gpio_abc_pkg::*;

    // ------------------------------------------------------------
    // Selector decode
    // ------------------------------------------------------------
    // Each pin looks only at its own two selector bits.
    always_comb begin
        pin_mode_t mode;
        mode = MODE_INPUT;
        for (int i = 0; i < `PIN_COUNT; i++) begin
            mode = pin_mode_t'(bus.sel[i*`SEL_WIDTH +: `SEL_WIDTH]);
            bus.pad_out[i] = 1'b0;
            bus.pad_oe[i] = 1'b0;
            bus.out_mode[i] = 1'b0;
            case (mode)
                MODE_OUTPUT: begin
                    // Stored data drives the pin.
                    bus.pad_out[i] = bus.data[i];
                    bus.pad_oe[i] = 1'b1;
                    bus.out_mode[i] = 1'b1;
                end
                MODE_ALT1: begin
                    // Peripheral 1 owns level and enable.
                    bus.pad_out[i] = bus.alt1_out[i];
                    bus.pad_oe[i] = bus.alt1_oe[i];
                end
                MODE_ALT2: begin
                    // A reserved code on a pin without a second function leaves
                    // the pad undriven, so a software slip cannot short a net.
                    if (ALT2_PINS[i]) begin
                        bus.pad_out[i] = bus.alt2_out[i];
                        bus.pad_oe[i] = bus.alt2_oe[i];
                    end
                end
                default: begin
                    // Input: the pad floats.
                    bus.pad_oe[i] = 1'b0;
                end
            endcase
        end
    end

endmodule

// ### rtl/gpio_abc_top.sv
// Register-controlled general-purpose I/O for ports A, B and C.
// Assumes an Avalon-MM master with byte addresses and synchronous pad inputs.
//
// Function
// - Data register holds eight pin bits only.
// - All six registers reset to zero.
// - Output pin reads back its stored bit.
// - Input pin reads back its sampled level.
// - Written data is stored and drives outputs.
// - Two selector bits per pin, bits 15:0.
// - 00 input, 01 function 1, 10 output.
// - Port A code 11: function 2, pins 7,6,3,2.
// - Port C code 11: function 2, pins 7-3.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`include "gpio_abc_regs.svh"

module gpio_abc_top (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Avalon-MM slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pads of the three ports.
    input wire gpio_abc_pkg::port_bits_t pad_in,
    output gpio_abc_pkg::port_bits_t pad_out,
    output gpio_abc_pkg::port_bits_t pad_oe,
    // Alternate-function peripherals.
    input wire gpio_abc_pkg::port_bits_t alt1_out,
    input wire gpio_abc_pkg::port_bits_t alt1_oe,
    input wire gpio_abc_pkg::port_bits_t alt2_out,
    input wire gpio_abc_pkg::port_bits_t alt2_oe,
    output gpio_abc_pkg::port_bits_t pin_level
);
    import gpio_abc_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe; // Release shift register.
    logic rst_n; // Synchronised reset used everywhere else.

    // Assert at once, release after two clock edges.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [2:0][7:0] pin_data; // Stored data per port.
    pin_function_t pin_function [3]; // Selector word per port.
    logic [2:0][7:0] out_mode; // Output-mode pins per port.
    logic [2:0] reg_port; // Port addressed by the request.
    logic reg_is_fnc; // Request targets a function register.
    logic reg_hit; // Request targets a mapped register.
    logic write_go; // Write takes effect this edge.

    // Decode the byte address: each port owns a pair of words.
    always_comb begin
        reg_port = 3'h0;
        reg_is_fnc = avs_address[2];
        reg_hit = (avs_address[1:0] == 2'h0);
        case (avs_address[4:3])
            2'h0: reg_port = 3'h1;
            2'h1: reg_port = 3'h2;
            2'h2: reg_port = 3'h4;
            default: reg_hit = 1'b0;
        endcase
    end

    // A write lands on the edge where the master sees the wait released.
    assign write_go = avs_write && !avs_waitrequest && reg_hit;

    // Data registers: only byte lane 0 is implemented.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_data <= {3{`RST_PIN_DATA}};
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (write_go && reg_port[p] && !reg_is_fnc && avs_byteenable[0]) begin
                    pin_data[p] <= avs_writedata[`DATA_FIELD_MSB:0];
                end
            end
        end
    end

    // Function registers: lanes 0 and 1; narrower accesses are honoured per
    // lane even though software is expected to use 16 or 32 bits.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < 3; p++) begin
                pin_function[p] <= `RST_PIN_FUNCTION;
            end
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (write_go && reg_port[p] && reg_is_fnc) begin
                    if (avs_byteenable[0]) begin
                        pin_function[p][7:0] <= avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        pin_function[p][15:8] <= avs_writedata[15:8];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin multiplexers
    // ------------------------------------------------------------
    pad_mux_if mux_bus [3] ();

    localparam logic [2:0][7:0] ALT2_MAP = {
        `ALT2_PINS_PORT_C, `ALT2_PINS_PORT_B, `ALT2_PINS_PORT_A
    };

    for (genvar p = 0; p < 3; p++) begin : g_port
        assign mux_bus[p].sel = pin_function[p];
        assign mux_bus[p].data = pin_data[p];
        assign mux_bus[p].alt1_out = alt1_out[p];
        assign mux_bus[p].alt1_oe = alt1_oe[p];
        assign mux_bus[p].alt2_out = alt2_out[p];
        assign mux_bus[p].alt2_oe = alt2_oe[p];
        assign out_mode[p] = mux_bus[p].out_mode;

        gpio_pin_mux #(
            .ALT2_PINS(ALT2_MAP[p])
        ) u_mux (
            .bus(mux_bus[p])
        );

        // Pads and levels come from flip-flops to keep outputs glitch free.
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                pad_out[p] <= 8'h00;
                pad_oe[p] <= 8'h00;
                pin_level[p] <= 8'h00;
            end else begin
                pad_out[p] <= mux_bus[p].pad_out;
                pad_oe[p] <= mux_bus[p].pad_oe;
                pin_level[p] <= pad_in[p];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Output pins show stored data, all others the sampled level, which also
    // covers alternate-function pins.
    function automatic logic [7:0] read_back(input logic [7:0] data,
                                             input logic [7:0] level,
                                             input logic [7:0] omask);
        read_back = (data & omask) | (level & ~omask);
    endfunction

    logic [31:0] next_readdata; // Word for the current read.

    // Unmapped offsets read as zero; unused upper bits are always zero.
    always_comb begin
        next_readdata = 32'h0000_0000;
        for (int p = 0; p < 3; p++) begin
            if (reg_hit && reg_port[p]) begin
                if (reg_is_fnc) begin
                    next_readdata = {16'h0000, pin_function[p]};
                end else begin
                    next_readdata = {24'h00_0000,
                        read_back(pin_data[p], pin_level[p], out_mode[p])};
                end
            end
        end
    end

    // One wait state per request: the first cycle lowers waitrequest for one
    // cycle and captures read data, so the answer is always two cycles long.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_reset_zero;
        $rose(rst_n) |-> (pin_data == 24'h0) && (pin_function[0] == 16'h0)
            && (pin_function[2] == 16'h0) && (pad_oe == 24'h0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Registers not zero after reset.");

    property p_data_upper_zero;
        (avs_read && !avs_waitrequest && !reg_is_fnc) |-> (avs_readdata[31:8] == 24'h0);
    endproperty
    a_data_upper_zero: assert property (p_data_upper_zero) else $error("Data bits above 7 set.");

    property p_fnc_upper_zero;
        (avs_read && !avs_waitrequest && reg_is_fnc) |-> (avs_readdata[31:16] == 16'h0);
    endproperty
    a_fnc_upper_zero: assert property (p_fnc_upper_zero) else $error("Selector bits above 15 set.");

    property p_write_stores;
        (write_go && reg_port[0] && !reg_is_fnc && avs_byteenable[0])
            |=> (pin_data[0] == $past(avs_writedata[7:0]));
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("Port A data not stored.");

    property p_out_readback;
        (avs_read && avs_waitrequest && reg_hit && reg_port[0] && !reg_is_fnc
            && pin_function[0] == 16'hAAAA) |=> (avs_readdata[7:0] == $past(pin_data[0]));
    endproperty
    a_out_readback: assert property (p_out_readback) else $error("Output read differs.");

    property p_in_readback;
        (avs_read && avs_waitrequest && reg_hit && reg_port[0] && !reg_is_fnc
            && pin_function[0] == 16'h0000) |=> (avs_readdata[7:0] == $past(pin_level[0]));
    endproperty
    a_in_readback: assert property (p_in_readback) else $error("Input read differs.");

    property p_out_drive;
        (pin_function[1][3:2] == 2'h2) |=> (pad_oe[1][1] && pad_out[1][1] == $past(pin_data[1][1]));
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("Output pin not driven.");

    property p_input_float;
        (pin_function[0][9:8] == 2'h0) |=> !pad_oe[0][4];
    endproperty
    a_input_float: assert property (p_input_float) else $error("Input pin driven.");

    property p_alt2_port_a;
        (pin_function[0][15:14] == 2'h3) |=> (pad_out[0][7] == $past(alt2_out[0][7])
            && pad_oe[0][7] == $past(alt2_oe[0][7]));
    endproperty
    a_alt2_port_a: assert property (p_alt2_port_a) else $error("Port A pin 7 not function 2.");

    property p_alt2_port_c;
        (pin_function[2][7:6] == 2'h3) |=> (pad_oe[2][3] == $past(alt2_oe[2][3]));
    endproperty
    a_alt2_port_c: assert property (p_alt2_port_c) else $error("Port C pin 3 not function 2.");

    property p_alt1_route;
        (pin_function[1][3:2] == 2'h1) |=> (pad_oe[1][1] == $past(alt1_oe[1][1]));
    endproperty
    a_alt1_route: assert property (p_alt1_route) else $error("Function 1 enable not routed.");

    property p_wait_one;
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("Wait state length wrong.");

    c_write_data: cover property (write_go && !reg_is_fnc);
    c_read_fnc: cover property (avs_read && !avs_waitrequest && reg_is_fnc);
    c_alt2_drive: cover property (pad_oe[2][7] && pin_function[2][15:14] == 2'h3);

endmodule

// ### testbench/gpio_pads_model.sv
// Behavioural model of the pads and of the alternate-function peripherals.
// Assumes the bench sets the level that the outside world puts on undriven pads.
`timescale 1ns/1ps

module gpio_pads_model (
    // Pad drive coming from the block.
    input wire gpio_abc_pkg::port_bits_t pad_out,
    input wire gpio_abc_pkg::port_bits_t pad_oe,
    // Level that the outside world drives where the block does not.
    input wire gpio_abc_pkg::port_bits_t ext_level,
    // Pad level seen by the block.
    output gpio_abc_pkg::port_bits_t pad_in,
    // Peripheral drive towards the block.
    output gpio_abc_pkg::port_bits_t alt1_out,
    output gpio_abc_pkg::port_bits_t alt1_oe,
    output gpio_abc_pkg::port_bits_t alt2_out,
    output gpio_abc_pkg::port_bits_t alt2_oe
);
    import gpio_abc_pkg::*;

    // ------------------------------------------------------------
    // Pad resolution
    // ------------------------------------------------------------
    // A driven pad follows the block; an undriven one follows the outside world.
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);

    // ------------------------------------------------------------
    // Peripheral patterns
    // ------------------------------------------------------------
    // Each port gets its own pattern so that a crossed port shows up at once.
    // Enables other than port B's function 2 enable are not all ones, so a pin whose peripheral lets go is also seen.
    assign alt1_out = {8'h69, 8'h5A, 8'h4B};
    assign alt1_oe = {8'hE7, 8'hDB, 8'h7E};
    assign alt2_out = {8'hC3, 8'h99, 8'h3C};
    assign alt2_oe = {8'hBD, 8'hFF, 8'hEE};
endmodule

// ### testbench/tb.sv
// Self-checking bench for the port A/B/C register and pad block.
// Assumes the pad model above stands on the far side of the pads.
`timescale 1ns/1ps

module tb;
    import gpio_abc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_sys = 1'b0; // System clock, 50 ns period.
    logic nrst = 1'b0; // Reset, held low from time zero.
    logic [4:0] avs_address = 5'h00; // Byte address of the request.
    logic avs_read = 1'b0; // Read request.
    logic avs_write = 1'b0; // Write request.
    logic [31:0] avs_writedata = 32'h0000_0000; // Write data.
    logic [3:0] avs_byteenable = 4'h0; // Byte lanes of the request.
    logic [31:0] avs_readdata; // Read data from the block.
    logic avs_waitrequest; // Stall from the block.
    port_bits_t ext_level = '0; // Level forced by the outside world.
    port_bits_t pad_in, pad_out, pad_oe; // Pad side.
    port_bits_t alt1_out, alt1_oe, alt2_out, alt2_oe; // Peripheral side.
    port_bits_t pin_level; // Pad level as the block hands it to peripherals.
    int errors = 0; // Mismatches seen.
    int compares = 0; // Comparisons made.

    always #25 clk_sys = ~clk_sys;

    gpio_abc_top i_gpio_abc_top (
        .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .alt1_out(alt1_out), .alt1_oe(alt1_oe), .alt2_out(alt2_out),
        .alt2_oe(alt2_oe), .pin_level(pin_level)
    );

    gpio_pads_model i_gpio_pads_model (
        .pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in),
        .alt1_out(alt1_out), .alt1_oe(alt1_oe), .alt2_out(alt2_out), .alt2_oe(alt2_oe)
    );

    // ------------------------------------------------------------
    // Verdict and comparisons
    // ------------------------------------------------------------
    // Single exit point, used by the main sequence and by the watchdog.
    task automatic close_out();
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares one 32-bit bus word.
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Compares one port's eight pad bits.
    task automatic check_pins(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------
    // Raises the request after an edge and holds it until waitrequest is seen low.
    task automatic bus_access(input logic wr, input logic [4:0] a, input logic [31:0] d,
                              input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        if (n >= 20) begin
            errors++;
            $display("MISMATCH waitrequest expected 0 seen %b", avs_waitrequest);
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] unused;
        bus_access(1'b1, a, d, be, unused);
    endtask

    task automatic bus_read(input logic [4:0] a, output logic [31:0] rd);
        bus_access(1'b0, a, 32'h0000_0000, 4'hF, rd);
    endtask

    // Holds reset for two cycles and waits until requests are allowed.
    task automatic do_reset();
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // Expected pad behaviour of one port
    // ------------------------------------------------------------
    // Works out pad enable, pad level and readback from selectors and stored data.
    task automatic exp_port(input int p, input logic [15:0] fnc, input logic [7:0] dat,
                            output logic [7:0] eo, output logic [7:0] eu,
                            output logic [7:0] er);
        for (int i = 0; i < 8; i++) begin
            case (fnc[2*i +: 2])
                2'b01: begin
                    eu[i] = alt1_out[p][i];
                    eo[i] = alt1_oe[p][i];
                end
                2'b10: begin
                    eu[i] = dat[i];
                    eo[i] = 1'b1;
                end
                2'b11: begin
                    eu[i] = alt2_out[p][i];
                    eo[i] = alt2_oe[p][i];
                end
                default: begin
                    eu[i] = 1'b0;
                    eo[i] = 1'b0;
                end
            endcase
            eu[i] = eu[i] & eo[i];
            er[i] = (fnc[2*i +: 2] == 2'b10) ? dat[i] : (eo[i] ? eu[i] : ext_level[p][i]);
        end
    endtask

    // Programs one port, then checks its pads and both registers.
    // Upper bits are written as ones so that a stray implemented bit reads back.
    task automatic run_port(input int p, input logic [15:0] fnc, input logic [7:0] dat);
        logic [31:0] rd;
        logic [7:0] eo, eu, er;
        exp_port(p, fnc, dat, eo, eu, er);
        bus_write(5'(8 * p), {24'hFFFFFF, dat}, 4'hF);
        bus_write(5'(8 * p + 4), {16'hFFFF, fnc}, 4'hF);
        repeat (3) @(posedge clk_sys);
        check_pins("pad_oe", eo, pad_oe[p]);
        check_pins("pad_out", eu, pad_out[p] & eo);
        check_pins("pin_level", er, pin_level[p]);
        bus_read(5'(8 * p + 4), rd);
        check_word("pin_function", {16'h0000, fnc}, rd);
        bus_read(5'(8 * p), rd);
        check_word("pin_data", {24'h000000, er}, rd);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    // Mixed tables put every selector code on every port where it is legal.
    int cp[7] = '{0, 0, 0, 1, 1, 2, 2};
    logic [15:0] cf[7] = '{16'hAAAA, 16'h0000, 16'hF9F2, 16'h6189, 16'h5555, 16'hFFE4, 16'hAAAA};
    logic [7:0] cd[7] = '{8'hC3, 8'hC3, 8'h0F, 8'hE1, 8'h00, 8'h7E, 8'h81};

    initial begin
        logic [31:0] rd;
        do_reset();
        for (int r = 0; r < 6; r++) begin
            bus_read(5'(4 * r), rd);
            check_word("reset value", 32'h0000_0000, rd);
        end
        for (int p = 0; p < 3; p++) begin
            check_pins("pad_oe after reset", 8'h00, pad_oe[p]);
        end
        // Unmapped and misaligned places answer zero and take no write.
        bus_write(5'h18, 32'hFFFF_FFFF, 4'hF);
        bus_read(5'h18, rd);
        check_word("unmapped", 32'h0000_0000, rd);
        bus_read(5'h06, rd);
        check_word("misaligned", 32'h0000_0000, rd);
        ext_level <= {8'h96, 8'h3C, 8'hA5};
        for (int k = 0; k < 7; k++) begin
            run_port(cp[k], cf[k], cd[k]);
        end
        // Byte writes: lane 0 lands, lane 1 of a data register has no bits.
        bus_write(5'h10, 32'hFFFF_FF3C, 4'h1);
        bus_write(5'h10, 32'h0000_FF00, 4'h2);
        bus_read(5'h10, rd);
        check_word("byte write", 32'h0000_003C, rd);
        repeat (2) @(posedge clk_sys);
        check_pins("pad_out byte", 8'h3C, pad_out[2]);
        // A second reset clears the stored data as well as the selectors.
        do_reset();
        bus_read(5'h00, rd);
        check_word("input after reset", 32'h0000_00A5, rd);
        bus_write(5'h04, 32'h0000_AAAA, 4'h3);
        bus_read(5'h00, rd);
        check_word("stored after reset", 32'h0000_0000, rd);
        close_out();
    end

    // Watchdog well beyond the roughly 170 cycles the sequence needs.
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        close_out();
    end
endmodule
